// ===== design/mssc_cond_eval.sv
// Transition condition evaluator
`timescale 1ns/1ps
`include "mssc_defs.svh"
`default_nettype none

module mssc_cond_eval
  import mssc_pkg::*;
(
  // Condition codes
  input  wire logic [2:0] condition,
  input  wire logic [2:0] global_code,
  // Monitored source
  input  wire logic       level,
  input  wire logic       rise,
  input  wire logic       fall,
  // Result
  output logic            met
);

  logic [2:0] eff;

  // Global code resolves to the globally set condition
  always_comb
  begin
    eff = (condition == `MSSC_COND_GLOBAL) ? global_code : condition;
    case (eff)
      `MSSC_COND_RISE:    met = rise;
      `MSSC_COND_FALL:    met = fall;
      `MSSC_COND_HIGH:    met = level;
      `MSSC_COND_LOW:     met = ~level;
      `MSSC_COND_AUTO:    met = 1'b1;
      `MSSC_COND_BLEND_A: met = 1'b1;
      `MSSC_COND_BLEND_B: met = 1'b1;
      default:            met = 1'b0;
    endcase
  end

endmodule : mssc_cond_eval

`default_nettype wire

// ===== design/mssc_edge_detect.sv
// Edge detector for the start sources
`timescale 1ns/1ps
`default_nettype none

module mssc_edge_detect
  import mssc_pkg::*;
(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       reset_n,
  // Sampled sources and their edges
  input  wire logic [1:0] source,
  output logic      [1:0] rise,
  output logic      [1:0] fall
);

  logic [1:0] prev_q;
  logic [1:0] prev_d;

  // Previous sample; one compare per source gives exactly one pulse per edge
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_src
      assign prev_d[g] = source[g];
      assign rise[g]   = source[g] & ~prev_q[g];
      assign fall[g]   = ~source[g] & prev_q[g];
    end
  endgenerate

  // Sample register
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      prev_q <= 2'h0;
    else
      prev_q <= prev_d;
  end

endmodule : mssc_edge_detect

`default_nettype wire

// ===== design/mssc_sequence_control.sv
// Motion sequence start and transition control
`timescale 1ns/1ps
`include "mssc_defs.svh"
`default_nettype none

module mssc_sequence_control
  import mssc_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        reset_n,
  // Parameter access
  input  wire logic        param_write,
  input  wire logic        param_read,
  input  wire logic [15:0] param_address,
  input  wire logic [3:0]  param_index,
  input  wire logic [15:0] param_wdata,
  output logic      [15:0] param_rdata_q,
  output logic             param_ack_q,
  output logic             param_error_q,
  // Drive configuration
  input  wire logic        fieldbus_control,
  input  wire logic        sequential_mode,
  input  wire logic [7:0]  local_default_mode,
  input  wire logic [7:0]  operating_mode_select,
  input  wire logic        opmode_write,
  input  wire logic [1:0]  power_stage_auto_enable,
  input  wire logic [2:0]  global_start_condition,
  input  wire logic [3:0]  start_set_number,
  // Local inputs
  input  wire logic        enable_input,
  input  wire logic        start_dataset_input,
  input  wire logic        profile_start_assigned,
  input  wire logic        profile_start_input,
  // Positioning core
  input  wire logic        set_done,
  input  wire logic        target_reached,
  input  wire logic        standstill,
  input  wire logic [3:0]  next_set_number,
  output logic             set_start_q,
  output logic      [3:0]  set_number_q,
  output logic             blend_q,
  output logic             blend_type_b_q,
  // Drive state and status
  input  wire logic        warning_active,
  input  wire logic        halt_active,
  input  wire logic        error_active,
  input  wire logic        referenced,
  output logic             power_stage_on_q,
  output logic      [7:0]  active_mode_q,
  output logic             mode_start_q,
  output logic      [15:0] drive_status_word_q
);

  // ----------------------------------------
  // Parameter registers
  // ----------------------------------------
  logic [15:0] start_req_q, start_req_d;
  logic [2:0]  cond_mem_q [`MSSC_SET_COUNT];
  logic [2:0]  cond_mem_d [`MSSC_SET_COUNT];
  logic [15:0] rdata_d;
  logic        ack_d, error_d;
  logic        hit_req, hit_cond;

  assign hit_req  = (param_address == `MSSC_ADDR_START_REQ);
  assign hit_cond = (param_address == `MSSC_ADDR_NEXT_COND);

  // Writes out of range are refused so stored values stay legal
  always_comb
  begin
    start_req_d = start_req_q;
    cond_mem_d  = cond_mem_q;
    rdata_d     = param_rdata_q;
    ack_d       = param_write | param_read;
    error_d     = 1'b0;
    if (param_write)
    begin
      if (hit_req && param_wdata <= `MSSC_START_REQ_MAX)
        start_req_d = param_wdata;
      else if (hit_cond && param_wdata <= `MSSC_COND_MAX)
        cond_mem_d[param_index] = param_wdata[2:0];
      else
        error_d = 1'b1;
    end
    else if (param_read)
    begin
      if (hit_req)
        rdata_d = start_req_q;
      else if (hit_cond)
        rdata_d = {13'h0000, cond_mem_q[param_index]};
      else
      begin
        rdata_d = 16'h0000;
        error_d = 1'b1;
      end
    end
  end

  // Parameter storage; start request is volatile and clears on reset
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      start_req_q   <= `MSSC_RST_START_REQ;
      for (int i = 0; i < `MSSC_SET_COUNT; i++)
        cond_mem_q[i] <= `MSSC_RST_NEXT_COND;
      param_rdata_q <= 16'h0000;
      param_ack_q   <= 1'b0;
      param_error_q <= 1'b0;
    end
    else
    begin
      start_req_q   <= start_req_d;
      cond_mem_q    <= cond_mem_d;
      param_rdata_q <= rdata_d;
      param_ack_q   <= ack_d;
      param_error_q <= error_d;
    end
  end

  // ----------------------------------------
  // Power stage and operating mode
  // ----------------------------------------
  logic       boot_q, boot_d;
  logic       auto_on_q, auto_on_d;
  logic       power_d, mode_start_d;
  logic [7:0] mode_d;

  // Auto-enable is caught once after reset release, like a switch-on strap
  always_comb
  begin
    boot_d       = 1'b0;
    auto_on_d    = boot_q ? (power_stage_auto_enable == `MSSC_AUTO_ENABLE_ON) : auto_on_q;
    power_d      = enable_input | auto_on_q;
    mode_d       = active_mode_q;
    mode_start_d = 1'b0;
    if (!fieldbus_control && power_d && !power_stage_on_q)
    begin
      mode_d       = local_default_mode;
      mode_start_d = 1'b1;
    end
    else if (fieldbus_control && opmode_write)
    begin
      mode_d       = operating_mode_select;
      mode_start_d = 1'b1;
    end
  end

  // Power and mode registers
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      boot_q           <= 1'b1;
      auto_on_q        <= 1'b0;
      power_stage_on_q <= 1'b0;
      active_mode_q    <= 8'h00;
      mode_start_q     <= 1'b0;
    end
    else
    begin
      boot_q           <= boot_d;
      auto_on_q        <= auto_on_d;
      power_stage_on_q <= power_d;
      active_mode_q    <= mode_d;
      mode_start_q     <= mode_start_d;
    end
  end

  // ----------------------------------------
  // Start sources and conditions
  // ----------------------------------------
  logic       base_src, trans_src;
  logic [1:0] rise, fall;
  logic       global_met, trans_met;
  logic [2:0] cur_cond;
  logic       seq_enable;

  assign base_src   = fieldbus_control ? start_req_q[0] : start_dataset_input;
  assign trans_src  = base_src | (profile_start_assigned & profile_start_input);
  assign cur_cond   = cond_mem_q[set_number_q];
  assign seq_enable = power_stage_on_q & (active_mode_q == `MSSC_MODE_MOTION_SEQ);

  mssc_edge_detect u_edges
  (
    .clock   (clock),
    .reset_n (reset_n),
    .source  ({trans_src, base_src}),
    .rise    (rise),
    .fall    (fall)
  );

  // In sequential mode the first set waits on the global condition; a static level passes at once
  mssc_cond_eval u_global
  (
    .condition   (`MSSC_COND_GLOBAL),
    .global_code (global_start_condition),
    .level       (base_src),
    .rise        (rise[0]),
    .fall        (fall[0]),
    .met         (global_met)
  );

  // In sequential mode following sets wait on the condition of the set just ended
  mssc_cond_eval u_trans
  (
    .condition   (cur_cond),
    .global_code (global_start_condition),
    .level       (trans_src),
    .rise        (rise[1]),
    .fall        (fall[1]),
    .met         (trans_met)
  );

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  mssc_state_type state_q, state_d;
  logic [3:0]     first_set_q, first_set_d;
  logic [3:0]     set_number_d;
  logic           start_now, set_end_q, set_end_d;
  logic           blend_d, blend_b_d;
  logic           is_blend;

  assign is_blend = (cur_cond == `MSSC_COND_BLEND_A) || (cur_cond == `MSSC_COND_BLEND_B);

  // Stage power loss drops the sequence; blends hand over at target reached
  always_comb
  begin
    state_d      = state_q;
    first_set_d  = first_set_q;
    set_number_d = set_number_q;
    start_now    = 1'b0;
    blend_d      = 1'b0;
    blend_b_d    = 1'b0;
    case (state_q)
      ST_IDLE:
        if (seq_enable)
        begin
          first_set_d = fieldbus_control ? start_set_number : `MSSC_LOCAL_FIRST_SET;
          state_d     = ST_FIRST;
        end
      ST_FIRST:
        if (!seq_enable)
          state_d = ST_IDLE;
        else if (sequential_mode ? global_met : rise[0])
        begin
          start_now    = 1'b1;
          set_number_d = sequential_mode ? first_set_q : (fieldbus_control ? start_set_number : `MSSC_LOCAL_FIRST_SET);
          state_d      = ST_RUN;
        end
      ST_RUN:
        if (!seq_enable)
          state_d = ST_IDLE;
        else if (sequential_mode && is_blend && target_reached)
        begin
          start_now    = 1'b1;
          blend_d      = 1'b1;
          blend_b_d    = (cur_cond == `MSSC_COND_BLEND_B);
          set_number_d = next_set_number;
        end
        else if (set_done)
          state_d = sequential_mode ? ST_NEXT : ST_FIRST;
      ST_NEXT:
        if (!seq_enable)
          state_d = ST_IDLE;
        else if (trans_met)
        begin
          start_now    = 1'b1;
          set_number_d = next_set_number;
          state_d      = ST_RUN;
        end
      default:
        state_d = ST_IDLE;
    endcase
    // A start clears completion even if the old set ends in the same step
    set_end_d = start_now ? 1'b0 : (set_done | set_end_q);
  end

  // Sequencer registers
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q        <= ST_IDLE;
      first_set_q    <= `MSSC_LOCAL_FIRST_SET;
      set_number_q   <= `MSSC_LOCAL_FIRST_SET;
      set_start_q    <= 1'b0;
      set_end_q      <= 1'b0;
      blend_q        <= 1'b0;
      blend_type_b_q <= 1'b0;
    end
    else
    begin
      state_q        <= state_d;
      first_set_q    <= first_set_d;
      set_number_q   <= set_number_d;
      set_start_q    <= start_now;
      set_end_q      <= set_end_d;
      blend_q        <= blend_d;
      blend_type_b_q <= blend_b_d;
    end
  end

  // ----------------------------------------
  // Status word
  // ----------------------------------------
  logic [15:0] status_d;

  always_comb
  begin
    status_d                     = 16'h0000;
    status_d[`MSSC_BIT_WARNING]  = warning_active;
    status_d[`MSSC_BIT_HALT]     = halt_active;
    status_d[`MSSC_BIT_ERROR]    = error_active;
    status_d[`MSSC_BIT_END]      = set_end_d & standstill;
    status_d[`MSSC_BIT_REF]      = referenced;
  end

  // Status register
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      drive_status_word_q <= 16'h0000;
    else
      drive_status_word_q <= status_d;
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  start_req_range_a: assert property (start_req_q <= `MSSC_START_REQ_MAX)
    else $error("start request holds an illegal value");
  cond_write_a: assert property ((param_write && hit_cond && param_wdata <= `MSSC_COND_MAX)
    |=> cond_mem_q[$past(param_index)] == $past(param_wdata[2:0]))
    else $error("transition condition write not stored");
  opmode_start_a: assert property ((fieldbus_control && opmode_write)
    |=> mode_start_q && active_mode_q == $past(operating_mode_select))
    else $error("operating mode write did not start the mode");
  auto_power_a: assert property ((boot_q && power_stage_auto_enable == `MSSC_AUTO_ENABLE_ON)
    |-> ##2 power_stage_on_q)
    else $error("auto enable did not power the stage");
  direct_edge_a: assert property ((state_q == ST_FIRST && !sequential_mode && !rise[0])
    |=> !set_start_q)
    else $error("direct set launched without a rising edge");
  local_first_a: assert property ((state_q == ST_FIRST && start_now && !fieldbus_control)
    |=> set_number_q == `MSSC_LOCAL_FIRST_SET)
    else $error("local sequence did not begin with set zero");
  end_clear_a: assert property (set_start_q |-> !drive_status_word_q[`MSSC_BIT_END])
    else $error("completion bit set while a set starts");
  end_still_a: assert property (drive_status_word_q[`MSSC_BIT_END] |-> $past(standstill))
    else $error("completion reported without standstill");
  halt_warn_a: assert property ((halt_active || warning_active)
    |=> drive_status_word_q[`MSSC_BIT_HALT] == $past(halt_active)
        && drive_status_word_q[`MSSC_BIT_WARNING] == $past(warning_active))
    else $error("halt or warning bit missing");
  err_ref_a: assert property ((error_active || referenced)
    |=> drive_status_word_q[`MSSC_BIT_ERROR] == $past(error_active)
        && drive_status_word_q[`MSSC_BIT_REF] == $past(referenced))
    else $error("error or referenced bit missing");
  auto_next_a: assert property ((state_q == ST_NEXT && seq_enable && cur_cond == `MSSC_COND_AUTO)
    |=> set_start_q)
    else $error("automatic transition did not start next set");

  blend_cov: cover property (blend_q);
  seq_chain_cov: cover property (state_q == ST_NEXT ##[1:50] set_start_q);
  direct_cov: cover property (!sequential_mode && set_start_q);
  refused_cov: cover property (param_error_q);

endmodule : mssc_sequence_control

`default_nettype wire

// ===== include/mssc_defs.svh
// Constants of the motion sequence start control block
`ifndef MSSC_DEFS_SVH
`define MSSC_DEFS_SVH

// ----------------------------------------
// Parameter offsets and reset values
// ----------------------------------------
`define MSSC_ADDR_START_REQ 16'h2D06
`define MSSC_ADDR_NEXT_COND 16'h2D2E
`define MSSC_RST_START_REQ  16'h0000
`define MSSC_RST_NEXT_COND  3'h4
`define MSSC_START_REQ_MAX  16'h0001
`define MSSC_COND_MAX       16'h0007

// ----------------------------------------
// Transition condition codes
// ----------------------------------------
`define MSSC_COND_RISE    3'h0
`define MSSC_COND_FALL    3'h1
`define MSSC_COND_HIGH    3'h2
`define MSSC_COND_LOW     3'h3
`define MSSC_COND_GLOBAL  3'h4
`define MSSC_COND_AUTO    3'h5
`define MSSC_COND_BLEND_A 3'h6
`define MSSC_COND_BLEND_B 3'h7

// ----------------------------------------
// Modes, start-up and status layout
// ----------------------------------------
`define MSSC_AUTO_ENABLE_ON  2'h2
`define MSSC_MODE_MOTION_SEQ 8'h01
`define MSSC_LOCAL_FIRST_SET 4'h0
`define MSSC_SET_COUNT       16
`define MSSC_BIT_WARNING     7
`define MSSC_BIT_HALT        8
`define MSSC_BIT_ERROR       13
`define MSSC_BIT_END         14
`define MSSC_BIT_REF         15

`endif

// ===== include/mssc_pkg.sv
// Types shared by the motion sequence start control block
package mssc_pkg;

  // Sequencer states
  typedef enum logic [1:0]
  {
    ST_IDLE,
    ST_FIRST,
    ST_RUN,
    ST_NEXT
  } mssc_state_type;

endpackage : mssc_pkg

// ===== verification/motion_sequence_start_control_tb.sv
// Self-checking bench for the motion sequence start control
`timescale 1ns/1ps
`include "mssc_defs.svh"
`default_nettype none

module motion_sequence_start_control_tb
  import mssc_pkg::*;
  ;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic        clock, reset_n, param_write, param_read, fieldbus_control, sequential_mode, opmode_write;
  logic        enable_input, start_dataset_input, profile_start_assigned, profile_start_input;
  logic        warning_active, halt_active, error_active, referenced, set_done, target_reached, standstill;
  logic        param_ack_q, param_error_q, set_start_q, blend_q, blend_type_b_q, power_stage_on_q, mode_start_q;
  logic [15:0] param_address, param_wdata, param_rdata_q, drive_status_word_q;
  logic [7:0]  local_default_mode, operating_mode_select, active_mode_q;
  logic [3:0]  param_index, start_set_number, next_set_number, set_number_q;
  logic [2:0]  global_start_condition;
  logic [1:0]  power_stage_auto_enable;
  int          compares, miscompares;

  mssc_sequence_control dut_u (.clock, .reset_n, .param_write, .param_read, .param_address, .param_index,
    .param_wdata, .param_rdata_q, .param_ack_q, .param_error_q, .fieldbus_control, .sequential_mode,
    .local_default_mode, .operating_mode_select, .opmode_write, .power_stage_auto_enable,
    .global_start_condition, .start_set_number, .enable_input, .start_dataset_input, .profile_start_assigned,
    .profile_start_input, .set_done, .target_reached, .standstill, .next_set_number, .set_start_q,
    .set_number_q, .blend_q, .blend_type_b_q, .warning_active, .halt_active, .error_active, .referenced,
    .power_stage_on_q, .active_mode_q, .mode_start_q, .drive_status_word_q);

  mssc_core_model core_u (.clock, .reset_n, .set_start_q, .set_number_q, .set_done, .target_reached,
    .standstill, .next_set_number);

  // Free-running 200 MHz clock
  always #2.5 clock = ~clock;

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic tick;
    @(posedge clock);
    #1;
  endtask : tick

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test;
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test

  task automatic do_reset(input logic [1:0] auto_en, input logic fb, input logic seq);
    reset_n = 1'b0;
    power_stage_auto_enable = auto_en;
    fieldbus_control = fb;
    sequential_mode = seq;
    enable_input = 1'b0;
    repeat (10) tick;
    reset_n = 1'b1;
  endtask : do_reset

  // One strobe cycle, answer checked in the cycle after the taking edge
  task automatic param(input logic wr, input logic [15:0] addr, input logic [3:0] idx,
                       input logic [15:0] wd, input logic [15:0] exp_rd, input logic exp_err);
    tick;
    {param_write, param_read, param_address, param_index, param_wdata} = {wr, !wr, addr, idx, wd};
    tick;
    {param_write, param_read} = 2'h0;
    check({14'h0, param_ack_q, param_error_q}, {14'h0, 1'b1, exp_err});
    if (!wr)
      check(param_rdata_q, exp_rd);
  endtask : param

  // Bounded wait for a launch, then judge number, blend flags and cleared completion
  task automatic wait_start(input logic [3:0] num, input logic bl, input logic bb);
    int n;
    n = 0;
    tick;
    while (set_start_q !== 1'b1 && n < 40)
    begin
      tick;
      n++;
    end
    check({15'h0, set_start_q}, 16'h0001);
    check({12'h0, set_number_q}, {12'h0, num});
    check({14'h0, blend_q, blend_type_b_q}, {14'h0, bl, bb});
    check({15'h0, drive_status_word_q[`MSSC_BIT_END]}, 16'h0000);
  endtask : wait_start

  task automatic wait_done;
    int n;
    n = 0;
    while (set_done !== 1'b1 && n < 40)
    begin
      tick;
      n++;
    end
    check({15'h0, set_done}, 16'h0001);
  endtask : wait_done

  task automatic no_start(input int cycles);
    repeat (cycles)
    begin
      tick;
      check({15'h0, set_start_q}, 16'h0000);
    end
  endtask : no_start

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_params;
    logic [2:0] codes [8];
    codes = '{`MSSC_COND_AUTO, `MSSC_COND_RISE, `MSSC_COND_BLEND_A, `MSSC_COND_BLEND_B,
              `MSSC_COND_LOW, `MSSC_COND_FALL, `MSSC_COND_HIGH, `MSSC_COND_GLOBAL};
    param(1'b0, `MSSC_ADDR_START_REQ, 4'h0, 16'h0000, 16'h0000, 1'b0);
    param(1'b0, `MSSC_ADDR_NEXT_COND, 4'h0, 16'h0000, 16'h0004, 1'b0);
    param(1'b1, `MSSC_ADDR_START_REQ, 4'h0, 16'h0002, 16'h0000, 1'b1);
    param(1'b0, `MSSC_ADDR_START_REQ, 4'h0, 16'h0000, 16'h0000, 1'b0);
    param(1'b1, `MSSC_ADDR_NEXT_COND, 4'h0, 16'h0008, 16'h0000, 1'b1);
    param(1'b0, 16'h2D00, 4'h0, 16'h0000, 16'h0000, 1'b1);
    // Table entry i governs the handover after set i
    for (int i = 0; i < 8; i++)
    begin
      param(1'b1, `MSSC_ADDR_NEXT_COND, i[3:0], {13'h0, codes[i]}, 16'h0000, 1'b0);
      param(1'b0, `MSSC_ADDR_NEXT_COND, i[3:0], 16'h0000, {13'h0, codes[i]}, 1'b0);
    end
  endtask : test_params

  task automatic test_local_start;
    repeat (4) tick;
    check({15'h0, power_stage_on_q}, 16'h0000);
    enable_input = 1'b1;
    wait_start(4'h0, 1'b0, 1'b0);
    check({7'h0, power_stage_on_q, active_mode_q}, {8'h01, `MSSC_MODE_MOTION_SEQ});
  endtask : test_local_start

  task automatic test_transitions;
    wait_done;
    tick;
    check({15'h0, set_start_q}, 16'h0000);
    tick;
    check({11'h0, set_start_q, set_number_q}, 16'h0011);
    wait_done;
    no_start(8);
    check({15'h0, drive_status_word_q[`MSSC_BIT_END]}, 16'h0001);
    // Start input low first, so only the profile input can make the rise
    start_dataset_input = 1'b0;
    tick;
    {profile_start_assigned, profile_start_input} = 2'h3;
    wait_start(4'h2, 1'b0, 1'b0);
    {profile_start_assigned, profile_start_input, start_dataset_input} = 3'h1;
    wait_start(4'h3, 1'b1, 1'b0);
    wait_start(4'h4, 1'b1, 1'b1);
    wait_done;
    no_start(6);
    start_dataset_input = 1'b0;
    wait_start(4'h5, 1'b0, 1'b0);
    wait_done;
    start_dataset_input = 1'b1;
    no_start(6);
    start_dataset_input = 1'b0;
    wait_start(4'h6, 1'b0, 1'b0);
    wait_done;
    no_start(6);
    start_dataset_input = 1'b1;
    wait_start(4'h7, 1'b0, 1'b0);
    wait_start(4'h8, 1'b0, 1'b0);
  endtask : test_transitions

  task automatic test_status;
    int pos [4];
    pos = '{`MSSC_BIT_WARNING, `MSSC_BIT_HALT, `MSSC_BIT_ERROR, `MSSC_BIT_REF};
    for (int j = 0; j < 4; j++)
    begin
      {warning_active, halt_active, error_active, referenced} = 4'h8 >> j;
      repeat (2) tick;
      check(drive_status_word_q & 16'hA180, 16'h0001 << pos[j]);
    end
    {warning_active, halt_active, error_active, referenced} = 4'h0;
  endtask : test_status

  task automatic test_fieldbus;
    tick;
    check({15'h0, power_stage_on_q}, 16'h0000);
    tick;
    check({15'h0, power_stage_on_q}, 16'h0001);
    opmode_write = 1'b1;
    tick;
    opmode_write = 1'b0;
    check({7'h0, mode_start_q, active_mode_q}, {8'h01, `MSSC_MODE_MOTION_SEQ});
    param(1'b1, `MSSC_ADDR_NEXT_COND, 4'h9, 16'h0005, 16'h0000, 1'b0);
    param(1'b1, `MSSC_ADDR_START_REQ, 4'h0, 16'h0001, 16'h0000, 1'b0);
    wait_start(4'h9, 1'b0, 1'b0);
    wait_done;
    no_start(8);
    param(1'b1, `MSSC_ADDR_START_REQ, 4'h0, 16'h0001, 16'h0000, 1'b0);
    no_start(6);
    start_set_number = 4'h3;
    param(1'b1, `MSSC_ADDR_START_REQ, 4'h0, 16'h0000, 16'h0000, 1'b0);
    param(1'b1, `MSSC_ADDR_START_REQ, 4'h0, 16'h0001, 16'h0000, 1'b0);
    wait_start(4'h3, 1'b0, 1'b0);
  endtask : test_fieldbus

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial
  begin
    {clock, reset_n, param_write, param_read, opmode_write, enable_input} = 6'h00;
    {profile_start_assigned, profile_start_input, warning_active, halt_active} = 4'h0;
    {error_active, referenced, start_dataset_input} = 3'h1;
    {param_address, param_wdata, param_index} = 36'h0;
    {local_default_mode, operating_mode_select} = {`MSSC_MODE_MOTION_SEQ, `MSSC_MODE_MOTION_SEQ};
    {fieldbus_control, sequential_mode, power_stage_auto_enable} = 4'h4;
    global_start_condition = `MSSC_COND_HIGH;
    start_set_number = 4'h9;
    compares = 0;
    miscompares = 0;
    do_reset(2'h0, 1'b0, 1'b1);
    test_params;
    test_local_start;
    test_transitions;
    test_status;
    global_start_condition = `MSSC_COND_RISE;
    do_reset(`MSSC_AUTO_ENABLE_ON, 1'b1, 1'b0);
    test_fieldbus;
    finish_test;
  end

  // Whole run needs well under 4000 cycles
  initial
  begin
    #20000;
    miscompares++;
    finish_test;
  end

endmodule : motion_sequence_start_control_tb
`default_nettype wire

// ===== verification/mssc_core_model.sv
// Positioning core model that runs the data sets launched by the sequence control
`timescale 1ns/1ps
`default_nettype none

module mssc_core_model
  import mssc_pkg::*;
(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       reset_n,
  // Set launch from the sequence control
  input  wire logic       set_start_q,
  input  wire logic [3:0] set_number_q,
  // Core answers
  output logic            set_done,
  output logic            target_reached,
  output logic            standstill,
  output logic      [3:0] next_set_number
);
  // ----------------------------------------
  // Set execution
  // ----------------------------------------
  logic       busy_q;
  logic       done_q;
  logic       reached_q;
  logic [2:0] step_q;
  logic [3:0] next_q;

  // Target reached at step 2, set ends at step 5; a fresh launch reloads the run,
  // so a blended handover never sees the old set end
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      busy_q    <= 1'b0;
      done_q    <= 1'b0;
      reached_q <= 1'b0;
      step_q    <= 3'h0;
      next_q    <= 4'h0;
    end
    else
    begin
      done_q    <= 1'b0;
      reached_q <= 1'b0;
      if (set_start_q)
      begin
        busy_q <= 1'b1;
        step_q <= 3'h0;
        next_q <= set_number_q + 4'h1;
      end
      else if (busy_q)
      begin
        step_q    <= step_q + 3'h1;
        reached_q <= (step_q == 3'h2);
        done_q    <= (step_q == 3'h5);
        busy_q    <= (step_q != 3'h5);
      end
    end
  end

  // Done pulses in the first idle cycle after a set ends; motor stands whenever idle
  assign set_done        = done_q;
  assign target_reached  = reached_q;
  assign standstill      = !busy_q;
  assign next_set_number = next_q;

endmodule : mssc_core_model
`default_nettype wire
